// ===== verilog/rep_string_pkg.sv
// Shared constants and types for the repeated string move engine
package rep_string_pkg;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 32;
    localparam int PIECE_BYTES = 16;
    localparam int LINE_BYTES = 64;
    localparam logic [CNT_W-1:0] BYTE_SHORT_LIMIT = 32'h0000_0004;
    localparam logic [CNT_W-1:0] BYTE_MID_LIMIT = 32'h0000_0009;
    localparam logic [CNT_W-1:0] WIDE_SHORT_LIMIT = 32'h0000_000c;
    localparam logic [CNT_W-1:0] FAST_MIN_COUNT = 32'h0000_004c;
    localparam int BYTE_SHORT_CYC = 9;
    localparam int BYTE_LONG_START_CYC = 50;
    localparam int WIDE_SHORT_CYC = 20;
    localparam int WIDE_MID_START_CYC = 15;
    localparam int FAST_CLEAN_START_CYC = 40;
    localparam int FAST_SPLIT_START_CYC = 35;
    localparam int FAST_CLEAN_LINE_CYC = 4;
    localparam int FAST_SPLIT_LINE_CYC = 6;
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_DWORD,
        SIZE_QWORD
    } elem_size_t;

    typedef enum logic [2:0] {
        TIER_BYTE_SHORT,
        TIER_BYTE_LONG,
        TIER_WIDE_SHORT,
        TIER_WIDE_MID,
        TIER_FAST_CLEAN,
        TIER_FAST_SPLIT
    } tier_t;

    // Bytes per element as a shift amount
    function automatic logic [2:0] size_shift(input elem_size_t s);
        return {1'b0, s};
    endfunction : size_shift
endpackage : rep_string_pkg

// ===== verilog/rep_tier_select.sv
// Chooses the startup and throughput tier of a repeated string operation
`timescale 1ns/1ps
module rep_tier_select
    import rep_string_pkg::*;
(
    // Request shape
    input wire elem_size_t size_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic [ADDR_W-1:0] dst_addr_i,
    // Result
    output tier_t tier_o,
    output logic [TMR_W-1:0] start_cyc_o,
    output logic [TMR_W-1:0] line_cyc_o
);
    wire is_byte = (size_i == SIZE_BYTE);
    wire [3:0] line_off = dst_addr_i[3:0];
    // Unaligned start makes 16-byte pieces straddle lines; alignment never gates fast mode
    wire splits = (line_off != 4'h0);

    always_comb begin
        tier_o = TIER_WIDE_MID;
        start_cyc_o = TMR_W'(WIDE_MID_START_CYC);
        line_cyc_o = TMR_ONE;
        if (is_byte) begin
            if (count_i < BYTE_SHORT_LIMIT) begin
                tier_o = TIER_BYTE_SHORT;
                start_cyc_o = TMR_W'(BYTE_SHORT_CYC);
            end else begin
                tier_o = TIER_BYTE_LONG;
                // Counts 4..9 given the long startup too; reads as byte-by-byte path
                start_cyc_o = TMR_W'(BYTE_LONG_START_CYC);
            end
        end else if (count_i <= WIDE_SHORT_LIMIT) begin
            tier_o = TIER_WIDE_SHORT;
            start_cyc_o = TMR_W'(WIDE_SHORT_CYC);
        end else if (count_i >= FAST_MIN_COUNT) begin
            if (splits) begin
                tier_o = TIER_FAST_SPLIT;
                start_cyc_o = TMR_W'(FAST_SPLIT_START_CYC);
                line_cyc_o = TMR_W'(FAST_SPLIT_LINE_CYC);
            end else begin
                tier_o = TIER_FAST_CLEAN;
                start_cyc_o = TMR_W'(FAST_CLEAN_START_CYC);
                line_cyc_o = TMR_W'(FAST_CLEAN_LINE_CYC);
            end
        end
    end
endmodule : rep_tier_select

// ===== verilog/rep_string_engine.sv
// Repeated string copy/store sequencer with tiered startup and throughput
`timescale 1ns/1ps
module rep_string_engine
    import rep_string_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Pipeline request
    input wire logic start_i,
    input wire logic store_only_i,
    input wire elem_size_t size_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic [ADDR_W-1:0] src_addr_i,
    input wire logic [ADDR_W-1:0] dst_addr_i,
    // Pipeline status
    output logic busy_o,
    output logic done_o,
    output logic fast_mode_o,
    output logic [CNT_W-1:0] iteration_count_register_o,
    // Memory side
    output logic mem_req_o,
    output logic mem_store_only_o,
    output logic [ADDR_W-1:0] mem_src_o,
    output logic [ADDR_W-1:0] mem_dst_o,
    output logic [4:0] mem_bytes_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STARTUP,
        ST_MOVE,
        ST_HOLD
    } state_t;

    state_t state;
    tier_t tier;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] line_cyc;
    logic [1:0] piece_in_line;
    logic [2:0] shift;
    logic [CNT_W-1:0] remaining;

    tier_t sel_tier;
    logic [TMR_W-1:0] sel_start;
    logic [TMR_W-1:0] sel_line;
    state_t next_state;

    // Pieces per 64-byte line, and the startup tick at which short tiers settle
    localparam logic [TMR_W-1:0] LINE_PIECES = TMR_W'(LINE_BYTES / PIECE_BYTES);
    localparam logic [1:0] LAST_PIECE = 2'(LINE_BYTES / PIECE_BYTES - 1);
    localparam logic [TMR_W-1:0] BULK_AT = TMR_ONE + TMR_ONE;

    function automatic logic fast_tier(input tier_t t);
        return (t == TIER_FAST_CLEAN) || (t == TIER_FAST_SPLIT);
    endfunction : fast_tier

    // Address advance shared by source and destination
    function automatic logic [ADDR_W-1:0] advance(input logic [ADDR_W-1:0] a,
        input logic [4:0] n);
        return a + ADDR_W'(n);
    endfunction : advance

    rep_tier_select u_tier (
        .size_i(size_i),
        .count_i(count_i),
        .dst_addr_i(dst_addr_i),
        .tier_o(sel_tier),
        .start_cyc_o(sel_start),
        .line_cyc_o(sel_line)
    );

    wire is_fast = fast_tier(tier);
    wire sel_fast = fast_tier(sel_tier);
    // Short tiers finish the whole operation inside the fixed latency
    wire is_short = (tier == TIER_BYTE_SHORT) || (tier == TIER_WIDE_SHORT);
    wire [CNT_W-1:0] elems_per_piece = CNT_W'(PIECE_BYTES) >> shift;
    wire use_piece = is_fast && (remaining >= elems_per_piece);
    wire [CNT_W-1:0] step = use_piece ? elems_per_piece : CNT_W'(1);
    wire [CNT_W-1:0] next_remaining = remaining - step;
    wire [4:0] step_bytes = use_piece ? 5'(PIECE_BYTES) : 5'(6'h01 << shift);
    wire timer_done = (timer <= TMR_ONE);
    // Four 16-byte pieces make one 64-byte line
    wire line_end = (piece_in_line == LAST_PIECE) || !use_piece;

    // Decisions as named wires; the clocked blocks below register them, except the last, which advances mem_dst_o, and mem_src_o on copies only, itself
    wire take = (state == ST_IDLE) && start_i;
    wire in_startup = (state == ST_STARTUP);
    wire in_move = (state == ST_MOVE);
    wire in_hold = (state == ST_HOLD);
    wire startup_end = in_startup && timer_done;
    wire finish = (startup_end || in_hold) && (remaining == '0);
    wire move_last = in_move && (next_remaining == '0);
    // A clean line costs just its four issue cycles, so only split lines pause
    wire line_pause = in_move && !move_last && is_fast && line_end
        && (line_cyc > LINE_PIECES);
    // Short tiers: elements moved in bulk within the fixed latency
    wire bulk_clear = is_short && in_startup && (timer == BULK_AT);
    wire [TMR_W-1:0] next_timer = take ? sel_start
        : (startup_end || move_last) ? TMR_ONE
        : line_pause ? line_cyc - LINE_PIECES
        : (in_startup || in_hold) ? timer - TMR_ONE
        : timer;
    wire [CNT_W-1:0] next_count = take ? count_i
        : bulk_clear ? CNT_W'(0)
        : in_move ? next_remaining
        : remaining;
    wire [1:0] next_piece = take ? 2'h0
        : in_move ? piece_in_line + 2'h1
        : piece_in_line;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_i) begin
                    next_state = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (finish) begin
                    next_state = ST_IDLE;
                end else if (timer_done) begin
                    next_state = ST_MOVE;
                end
            end
            ST_MOVE: begin
                if (move_last || line_pause) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (finish) begin
                    next_state = ST_IDLE;
                end else if (timer_done) begin
                    next_state = ST_MOVE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Request shape is held for the whole run
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tier <= TIER_BYTE_SHORT;
            line_cyc <= '0;
            shift <= '0;
        end else if (take) begin
            tier <= sel_tier;
            line_cyc <= sel_line;
            shift <= size_shift(size_i);
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remaining <= '0;
            iteration_count_register_o <= '0;
            piece_in_line <= '0;
        end else begin
            remaining <= next_count;
            iteration_count_register_o <= next_count;
            piece_in_line <= next_piece;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            fast_mode_o <= 1'b0;
        end else begin
            done_o <= finish;
            if (take) begin
                busy_o <= 1'b1;
                fast_mode_o <= sel_fast;
            end else if (finish) begin
                busy_o <= 1'b0;
                fast_mode_o <= 1'b0;
            end
        end
    end

    // One element or piece per issue cycle
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_req_o <= 1'b0;
            mem_bytes_o <= '0;
        end else begin
            mem_req_o <= in_move;
            if (in_move) begin
                mem_bytes_o <= step_bytes;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_store_only_o <= 1'b0;
            mem_src_o <= '0;
            mem_dst_o <= '0;
        end else if (take) begin
            mem_store_only_o <= store_only_i;
            mem_src_o <= src_addr_i;
            mem_dst_o <= dst_addr_i;
        end else if (mem_req_o) begin
            // Advance past the move just shown; a store keeps its source
            mem_dst_o <= advance(mem_dst_o, mem_bytes_o);
            if (!mem_store_only_o) begin
                mem_src_o <= advance(mem_src_o, mem_bytes_o);
            end
        end
    end
endmodule : rep_string_engine

// ===== test/rep_string_engine_asserts.sv
// Checker for the repeated string move engine ports
`timescale 1ns/1ps
module rep_string_engine_asserts
    import rep_string_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire elem_size_t size_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic fast_mode_o,
    input wire logic [CNT_W-1:0] iteration_count_register_o,
    input wire logic mem_req_o,
    input wire logic [4:0] mem_bytes_o
);
    // Request shape as taken, since the inputs may move during the run
    elem_size_t sz;
    logic [CNT_W-1:0] cnt;
    wire go = start_i && !busy_o;
    wire is_byte = (sz == SIZE_BYTE);
    wire short_b = is_byte && (cnt < BYTE_SHORT_LIMIT);
    wire short_w = !is_byte && (cnt <= WIDE_SHORT_LIMIT);
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sz <= SIZE_BYTE;
            cnt <= '0;
        end else if (go) begin
            sz <= size_i;
            cnt <= count_i;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_start_busy: assert property (go |=> busy_o) else $error("start not taken");
    a_req_busy: assert property (mem_req_o |-> busy_o) else $error("move while idle");
    a_done_pulse: assert property (done_o |-> !busy_o ##1 !done_o) else $error("done held");
    a_done_zero: assert property (done_o |-> iteration_count_register_o == '0)
        else $error("count not zero at done");
    a_count_down: assert property (busy_o && $past(busy_o)
        && iteration_count_register_o != $past(iteration_count_register_o)
        |-> iteration_count_register_o < $past(iteration_count_register_o))
        else $error("count went up");
    a_byte_slow: assert property (busy_o && is_byte
        |-> !fast_mode_o && (!mem_req_o || mem_bytes_o == 5'h01)) else $error("byte op fast");
    a_fast_entry: assert property (mem_req_o && !is_byte && cnt >= FAST_MIN_COUNT
        |-> fast_mode_o) else $error("fast mode missed");
    a_fast_only: assert property (fast_mode_o |-> !is_byte && cnt >= FAST_MIN_COUNT)
        else $error("fast mode unwarranted");
    a_short_byte_time: assert property ($rose(busy_o) && short_b |-> ##[7:9] done_o)
        else $error("short byte latency");
    a_short_wide_time: assert property ($rose(busy_o) && short_w |-> ##[17:20] done_o)
        else $error("short wide latency");
    a_short_no_req: assert property (busy_o && (short_b || short_w) |-> !mem_req_o)
        else $error("move in short tier");
endmodule : rep_string_engine_asserts

bind rep_string_engine rep_string_engine_asserts rep_string_engine_asserts_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i), .size_i(size_i),
    .count_i(count_i), .busy_o(busy_o), .done_o(done_o), .fast_mode_o(fast_mode_o),
    .iteration_count_register_o(iteration_count_register_o), .mem_req_o(mem_req_o),
    .mem_bytes_o(mem_bytes_o));

// ===== test/mem_side_model.sv
// Memory-side model that tallies every move the engine issues
`timescale 1ns/1ps
module mem_side_model
    import rep_string_pkg::*;
(
    input wire logic mclk_i,
    input wire logic clear_i,
    input wire logic mem_req_i,
    input wire logic mem_store_only_i,
    input wire logic [ADDR_W-1:0] mem_src_i,
    input wire logic [ADDR_W-1:0] mem_dst_i,
    input wire logic [4:0] mem_bytes_i,
    output int moves_o,
    output int bytes_o,
    output int pieces_o,
    output int odd_o
);
    logic [ADDR_W-1:0] src0, src_next, dst_next;
    logic seen;
    // Odd: illegal size, a store whose source walks, or a move that skips bytes
    wire bad = !(mem_bytes_i inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        || (mem_store_only_i && seen && mem_src_i != src0)
        || (!mem_store_only_i && seen && mem_src_i != src_next)
        || (seen && mem_dst_i != dst_next);
    always @(posedge mclk_i) begin
        if (clear_i) begin
            moves_o <= 0;
            bytes_o <= 0;
            pieces_o <= 0;
            odd_o <= 0;
            seen <= 1'b0;
        end else if (mem_req_i) begin
            moves_o <= moves_o + 1;
            bytes_o <= bytes_o + int'(mem_bytes_i);
            pieces_o <= pieces_o + int'(mem_bytes_i == 5'h10);
            odd_o <= odd_o + int'(bad);
            src0 <= seen ? src0 : mem_src_i;
            src_next <= mem_src_i + ADDR_W'(mem_bytes_i);
            dst_next <= mem_dst_i + ADDR_W'(mem_bytes_i);
            seen <= 1'b1;
        end
    end
endmodule : mem_side_model

// ===== test/tb_rep_string_engine.sv
// Self-checking bench for the repeated string move engine
`timescale 1ns/1ps
module tb_rep_string_engine;
    import rep_string_pkg::*;
    logic mclk_i, resetn_i, start_i, store_only_i, clear, fm;
    elem_size_t size_i;
    logic [CNT_W-1:0] count_i, iteration_count_register_o;
    logic [ADDR_W-1:0] src_addr_i, dst_addr_i, mem_src_o, mem_dst_o;
    logic busy_o, done_o, fast_mode_o, mem_req_o, mem_store_only_o;
    logic [4:0] mem_bytes_o;
    int moves, bytes, pieces, odd, err_total, num_checks, lat, cycles;
    rep_string_engine rep_string_engine_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .start_i(start_i), .store_only_i(store_only_i), .size_i(size_i), .count_i(count_i),
        .src_addr_i(src_addr_i), .dst_addr_i(dst_addr_i), .busy_o(busy_o), .done_o(done_o),
        .fast_mode_o(fast_mode_o), .iteration_count_register_o(iteration_count_register_o),
        .mem_req_o(mem_req_o), .mem_store_only_o(mem_store_only_o), .mem_src_o(mem_src_o),
        .mem_dst_o(mem_dst_o), .mem_bytes_o(mem_bytes_o));
    mem_side_model mem_side_model_i (.mclk_i(mclk_i), .clear_i(clear), .mem_req_i(mem_req_o),
        .mem_store_only_i(mem_store_only_o), .mem_src_i(mem_src_o), .mem_dst_i(mem_dst_o),
        .mem_bytes_i(mem_bytes_o),
        .moves_o(moves), .bytes_o(bytes), .pieces_o(pieces), .odd_o(odd));
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rng(input int lo, input int hi);
        num_checks++;
        if (lat < lo || lat > hi) begin
            err_total++;
            $display("unexpected latency at %0t: got %h expected %h..%h", $time, lat, lo, hi);
        end
    endtask : rng
    // One operation; poke repeats start once while busy, which must be ignored
    task run(input elem_size_t s, input logic [31:0] n, input logic [31:0] dst,
             input logic so, input logic poke);
        @(posedge mclk_i);
        clear <= 1'b1;
        size_i <= s;
        count_i <= n;
        dst_addr_i <= dst;
        store_only_i <= so;
        start_i <= 1'b1;
        lat = -1;
        fm = 1'b0;
        do begin
            @(posedge mclk_i);
            clear <= 1'b0;
            start_i <= (lat == -1) && poke;
            lat++;
            #1;
            fm = fm | (fast_mode_o === 1'b1);
        end while (done_o !== 1'b1 && lat < 3000);
        @(posedge mclk_i);
        #1;
        chk(busy_o, 1'b0);
        chk(iteration_count_register_o, 32'h0000_0000);
        chk(odd, 32'h0000_0000);
    endtask : run
    task sc_byte;
        run(SIZE_BYTE, 32'h0000_0003, 32'h0000_0000, 1'b0, 1'b0);
        rng(8, 10);
        chk(fm, 1'b0);
        run(SIZE_BYTE, 32'h0000_0014, 32'h0000_0100, 1'b0, 1'b1);
        rng(70, 74);
        chk(moves, 32'h0000_0014);
        chk(fm, 1'b0);
    endtask : sc_byte
    task sc_wide;
        elem_size_t s[3] = '{SIZE_WORD, SIZE_DWORD, SIZE_QWORD};
        int n[3] = '{13, 30, 75};
        int w[3] = '{2, 4, 8};
        run(SIZE_WORD, 32'h0000_000c, 32'h0000_0000, 1'b0, 1'b0);
        rng(19, 21);
        // Store op on the middle entry: source must not advance
        for (int i = 0; i < 3; i++) begin
            run(s[i], n[i], 32'h0000_0200, i == 1, 1'b1);
            rng(15 + n[i] - 1, 15 + n[i] + 3);
            chk(bytes, n[i] * w[i]);
            chk(fm, 1'b0);
        end
    endtask : sc_wide
    task sc_fast;
        elem_size_t s[3] = '{SIZE_QWORD, SIZE_QWORD, SIZE_WORD};
        logic [31:0] d[3] = '{32'h0000_0400, 32'h0000_0404, 32'h0000_0400};
        int n[3] = '{80, 80, 76};
        int t[3] = '{80, 95, 50};
        for (int i = 0; i < 3; i++) begin
            run(s[i], n[i], d[i], 1'b0, 1'b0);
            chk(fm, 1'b1);
            chk(bytes, i == 2 ? 152 : 640);
            chk(pieces, i == 2 ? 9 : 40);
            rng(t[i] - 4, t[i] + 6);
        end
    endtask : sc_fast
    initial begin
        resetn_i = 1'b0;
        start_i = 1'b0;
        store_only_i = 1'b0;
        size_i = SIZE_BYTE;
        count_i = '0;
        src_addr_i = 32'h0000_1000;
        dst_addr_i = '0;
        clear = 1'b1;
        err_total = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge mclk_i);
        resetn_i <= 1'b1;
        sc_byte();
        sc_wide();
        sc_fast();
        conclude();
    end
endmodule : tb_rep_string_engine
